// File: rtl/ctsf_core.sv
`timescale 1ns/1ns
// How it works
// RL1: Three transmit buffers, each 13 bytes deep.
// RL2: Each buffer carries an 8-bit local priority.
// RL3: Software clears empty flag to schedule buffer.
// RL4: Sent buffer gets empty flag and interrupt.
// RL5: Smallest priority value wins arbitration.
// RL6: Selection reruns on every arbitration attempt.
// RL7: Abort granted only when buffer not transmitting.
// RL8: Abort acknowledge tells aborted from sent.
// RL9: Single mode matches 29 id bits plus RTR/IDE/SRR.
// RL10: Dual mode: 11 bits+RTR or 14 MSBs; code compares the upper and lower 16-bit halves of the id word.
// RL11: Quad mode compares first eight id bits; code gives each filter its own byte lane of the id word.
// RL12: Pattern defines bits; mask bit ignores bit.
// RL13: Copy to foreground and set full on hit.
// RL14: Two-bit hit index, lowest filter wins.
// RL15: Eleven maskable sources onto four requests.
// RL16: Transmit request while enabled empty buffer.
// RL17: Receive interrupt right after end of frame.
// RL18: Bus activity in sleep sets wakeup flag.
// RL19: Warning flags when error counter reaches 96.
// RL20: Passive flags when counter exceeds 127.
// RL21: Bus-off flag when transmit counter exceeds 255.
// RL22: Write 1 clears flag unless condition persists.
// RL23: Both receive buffers full: discard, set overrun.
// RL24: Own frames never reach foreground outside loop-back.
// RL25: Each request ORs enabled source flags.
module ctsf_core
    import ctsf_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic tx_arb_start,
    output logic tx_req,
    output logic [1:0] tx_sel,
    input wire logic tx_done,
    input wire logic tx_active,
    input wire logic rx_eof,
    input wire logic [31:0] rx_id,
    input wire logic rx_own,
    input wire logic loopback,
    input wire logic sleep_mode,
    input wire logic bus_activity,
    input wire logic [CNT_W-1:0] rx_err_cnt,
    input wire logic [CNT_W-1:0] tx_err_cnt,
    output logic fg_load,
    output logic [1:0] hit_index,
    output logic irq_wakeup,
    output logic irq_error,
    output logic irq_rx,
    output logic irq_tx
);
    import ctsf_pkg::*;

    logic [NUM_TXB-1:0] txe_r;
    logic [NUM_TXB-1:0] abort_req_r;
    logic [NUM_TXB-1:0] abort_ack_r;
    logic [NUM_TXB-1:0] tx_en_r;
    logic [LOCAL_PRIORITY_W-1:0] local_priority_r [NUM_TXB];
    logic [7:0] rf_r;
    logic [7:0] rx_en_r;
    logic [1:0] fmode_r;
    logic [31:0] pattern_r;
    logic [31:0] mask_r;
    logic [1:0] hit_r;
    logic bg_full_r;
    logic [1:0] bg_hit_r;
    logic sched_valid_r;
    logic [1:0] sched_r;
    logic [7:0] aw_addr_r;
    logic aw_have_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic w_have_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    // Buffer memory is outside this block; only scheduling state lives here
    ctsf_sel_if sif ();
    ctsf_tx_select u_sel (.s(sif)); // RL5

    assign sif.pending = ~txe_r; // RL1 RL3
    assign sif.local_priority = {local_priority_r[2], local_priority_r[1], local_priority_r[0]}; // RL2

    // AXI write path: address and data taken in either order
    wire do_write = aw_have_r && w_have_r && !bvalid_r;
    assign s_axi_awready = !aw_have_r && !bvalid_r;
    assign s_axi_wready = !w_have_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    wire wr_txf = do_write && aw_addr_r == REG_TX_FLAG && w_strb_r[0];
    wire wr_txc = do_write && aw_addr_r == REG_TX_CTRL && w_strb_r[0];
    wire wr_rf = do_write && aw_addr_r == REG_RX_FLAG && w_strb_r[0];
    wire wr_ren = do_write && aw_addr_r == REG_RX_EN && w_strb_r[0];
    wire wr_acc = do_write && aw_addr_r == REG_ACC_CTRL && w_strb_r[0];
    wire wr_pat = do_write && aw_addr_r == REG_PATTERN;
    wire wr_msk = do_write && aw_addr_r == REG_MASK;
    wire wr_pri = do_write && aw_addr_r == REG_LOCAL_PRIORITY;
    wire wr_known = aw_addr_r inside {REG_TX_FLAG, REG_TX_CTRL, REG_RX_FLAG, REG_RX_EN,
        REG_ACC_CTRL, REG_PATTERN, REG_MASK, REG_LOCAL_PRIORITY};
    wire rd_go = s_axi_arvalid && !rvalid_r;

    // Acceptance filter
    wire [31:0] id_eq = ~(rx_id ^ pattern_r) | mask_r; // RL12
    wire single_hit = &id_eq; // RL9
    logic [3:0] sec_hit;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sec
            // Quad sections each look at one byte lane of the id word
            assign sec_hit[g] = &id_eq[8*g +: 8]; // RL11
        end
    endgenerate
    // Dual: filter 0 compares the upper 16 bits of the id word, filter 1 the lower 16
    wire [1:0] dual_hit = {&id_eq[15:0], &id_eq[31:16]}; // RL10
    logic any_hit;
    logic [1:0] hit_nxt;
    always_comb begin
        any_hit = 1'b0;
        hit_nxt = 2'd0;
        unique case (ctsf_fmode_t'(fmode_r))
            FM_SINGLE: begin
                any_hit = single_hit;
            end
            FM_DUAL: begin
                any_hit = |dual_hit;
                hit_nxt = dual_hit[0] ? 2'd0 : 2'd1; // RL14
            end
            FM_QUAD: begin
                any_hit = |sec_hit;
                hit_nxt = sec_hit[3] ? 2'd0 : sec_hit[2] ? 2'd1 : sec_hit[1] ? 2'd2 : 2'd3; // RL14
            end
            FM_OFF: begin
                any_hit = 1'b0;
            end
        endcase
    end

    // Receive path
    wire rx_take = rx_eof && (!rx_own || loopback); // RL24
    wire both_full = rf_r[RF_RXF] && bg_full_r;
    wire rx_overrun = rx_eof && both_full; // RL23
    // A hit while the background still waits must not overtake it
    wire load_fg = rx_take && any_hit && !rf_r[RF_RXF] && !bg_full_r; // RL13 RL17
    wire bg_stays = rx_take && any_hit && (rf_r[RF_RXF] || bg_full_r) && !both_full;
    wire bg_drain = bg_full_r && !rf_r[RF_RXF];
    assign fg_load = load_fg || bg_drain;

    // Receive flag conditions; while true the flag cannot be cleared
    logic [7:0] rf_cond;
    always_comb begin
        rf_cond = 8'h00;
        rf_cond[RF_WUP] = sleep_mode && bus_activity; // RL18
        rf_cond[RF_RWRN] = rx_err_cnt >= CNT_W'(WARN_LIMIT); // RL19
        rf_cond[RF_TWRN] = tx_err_cnt >= CNT_W'(WARN_LIMIT); // RL19
        rf_cond[RF_RERR] = rx_err_cnt > CNT_W'(PASSIVE_LIMIT); // RL20
        rf_cond[RF_TERR] = tx_err_cnt > CNT_W'(PASSIVE_LIMIT); // RL20
        rf_cond[RF_BOFF] = tx_err_cnt > CNT_W'(BUSOFF_LIMIT); // RL21
        rf_cond[RF_OVR] = rx_overrun; // RL23
        rf_cond[RF_RXF] = fg_load; // RL13
    end
    wire [7:0] rf_clr = wr_rf ? w_data_r[7:0] : 8'h00;
    // Set wins over clear; clear ignored while condition holds
    wire [7:0] rf_nxt = (rf_r & ~rf_clr) | rf_cond; // RL22

    // Transmit side
    wire [NUM_TXB-1:0] txe_clr = wr_txf ? w_data_r[NUM_TXB-1:0] : '0;
    logic [NUM_TXB-1:0] done_vec;
    logic [NUM_TXB-1:0] abort_ok;
    generate
        for (g = 0; g < NUM_TXB; g++) begin : g_tx
            assign done_vec[g] = tx_done && sched_valid_r && sched_r == 2'(g); // RL4
            // Buffer on the wire cannot be aborted
            assign abort_ok[g] = abort_req_r[g] && !txe_r[g] &&
                !(tx_active && sched_valid_r && sched_r == 2'(g)); // RL7
        end
    endgenerate
    wire [NUM_TXB-1:0] txe_set = done_vec | abort_ok;
    wire [NUM_TXB-1:0] txe_nxt = (txe_r | txe_set) & ~(txe_clr & ~txe_set); // RL3 RL4
    wire [NUM_TXB-1:0] ack_nxt = (abort_ack_r & ~txe_clr) & ~done_vec | abort_ok; // RL8
    wire [NUM_TXB-1:0] areq_set = wr_txc ? w_data_r[NUM_TXB-1:0] : '0;
    wire [NUM_TXB-1:0] areq_nxt = (abort_req_r | areq_set) & ~txe_nxt;

    assign tx_req = sched_valid_r && !txe_r[sched_r];
    assign tx_sel = sched_r;

    // Interrupt requests
    assign irq_tx = |(txe_r & tx_en_r); // RL16 RL25 RL15
    assign irq_rx = rf_r[RF_RXF] && rx_en_r[RF_RXF]; // RL25 RL15
    assign irq_wakeup = rf_r[RF_WUP] && rx_en_r[RF_WUP]; // RL25 RL15
    assign irq_error = |(rf_r[6:1] & rx_en_r[6:1]); // RL25 RL15
    assign hit_index = hit_r;

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        unique case (s_axi_araddr)
            REG_TX_FLAG: rd_mux = {25'h0, tx_en_r, 1'b0, txe_r};
            REG_TX_CTRL: rd_mux = {25'h0, abort_ack_r, 1'b0, abort_req_r};
            REG_RX_FLAG: rd_mux = {24'h0, rf_r};
            REG_RX_EN: rd_mux = {24'h0, rx_en_r};
            REG_ACC_CTRL: rd_mux = {26'h0, hit_r, 2'h0, fmode_r};
            REG_PATTERN: rd_mux = pattern_r;
            REG_MASK: rd_mux = mask_r;
            REG_LOCAL_PRIORITY: rd_mux = {8'h0, local_priority_r[2], local_priority_r[1], local_priority_r[0]};
            default: rd_mux = 32'h0;
        endcase
    end
    wire rd_known = s_axi_araddr inside {REG_TX_FLAG, REG_TX_CTRL, REG_RX_FLAG, REG_RX_EN,
        REG_ACC_CTRL, REG_PATTERN, REG_MASK, REG_LOCAL_PRIORITY};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= AXI_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_known ? AXI_OKAY : AXI_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= AXI_OKAY;
        end else if (rd_go) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= rd_known ? AXI_OKAY : AXI_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            txe_r <= TXE_RESET;
            abort_req_r <= '0;
            abort_ack_r <= '0;
            tx_en_r <= '0;
            rf_r <= RF_RESET;
            rx_en_r <= RX_EN_RESET;
            fmode_r <= 2'h0;
            pattern_r <= 32'h0;
            mask_r <= 32'h0;
            hit_r <= 2'h0;
            bg_hit_r <= 2'h0;
            bg_full_r <= 1'b0;
            sched_valid_r <= 1'b0;
            sched_r <= 2'h0;
            for (int i = 0; i < NUM_TXB; i++) begin
                local_priority_r[i] <= '0;
            end
        end else begin
            txe_r <= txe_nxt;
            abort_ack_r <= ack_nxt;
            abort_req_r <= areq_nxt;
            rf_r <= rf_nxt;
            if (wr_txf) tx_en_r <= w_data_r[6:4];
            if (wr_ren) rx_en_r <= w_data_r[7:0];
            // Filter setup is software's job to keep stable while on-line
            if (wr_acc) fmode_r <= w_data_r[1:0];
            if (wr_pat) pattern_r <= w_data_r;
            if (wr_msk) mask_r <= w_data_r;
            if (wr_pri) begin
                for (int i = 0; i < NUM_TXB; i++) begin
                    local_priority_r[i] <= w_data_r[LOCAL_PRIORITY_W*i +: LOCAL_PRIORITY_W]; // RL2
                end
            end
            if (load_fg) hit_r <= hit_nxt; // RL14
            else if (bg_drain) hit_r <= bg_hit_r; // RL14
            if (bg_stays) begin
                bg_full_r <= 1'b1;
                bg_hit_r <= hit_nxt; // RL14
            end else if (bg_drain) begin
                bg_full_r <= 1'b0;
            end
            if (tx_arb_start) begin
                sched_valid_r <= sif.found; // RL6
                sched_r <= sif.winner; // RL5 RL6
            end else if (tx_done || (sched_valid_r && txe_nxt[sched_r] && !tx_active)) begin
                sched_valid_r <= 1'b0;
            end
        end
    end

    txe_set_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL4
        tx_done && sched_valid_r |=> txe_r[$past(sched_r)])
        else $error("txe not set after transmit");
    ack_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL8
        tx_done && sched_valid_r && !abort_ok[sched_r] |=> !abort_ack_r[$past(sched_r)])
        else $error("ack set on sent buffer");
    abort_busy_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL7
        tx_active && sched_valid_r && !tx_done && !abort_ack_r[sched_r] |=> !abort_ack_r[$past(sched_r)])
        else $error("abort granted while on wire");
    sel_local_priority_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL5
        tx_arb_start && !txe_r[0] && !txe_r[1] && local_priority_r[1] < local_priority_r[0] |=> sched_r != 2'd0)
        else $error("wrong priority winner");
    own_frame_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL24
        rx_eof && rx_own && !loopback && !rf_r[RF_RXF] && !bg_full_r |=> !rf_r[RF_RXF])
        else $error("own frame accepted");
    ovr_set_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL23
        rx_eof && rf_r[RF_RXF] && bg_full_r |=> rf_r[RF_OVR] && $stable(hit_r))
        else $error("overrun not flagged");
    clr_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL21 RL22
        rf_cond[RF_BOFF] |=> rf_r[RF_BOFF])
        else $error("bus off flag lost");
    warn_set_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL19
        rx_err_cnt == CNT_W'(WARN_LIMIT) |=> rf_r[RF_RWRN])
        else $error("warning flag missing");
    rx_irq_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL17 RL13
        load_fg && rx_en_r[RF_RXF] && !wr_ren |=> irq_rx)
        else $error("receive irq late");
    tx_irq_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL16
        |(txe_set & tx_en_r) && !wr_txf |=> irq_tx)
        else $error("tx irq missing after release");
    cov_abort_c: cover property (@(posedge aclk) disable iff (!aresetn) |abort_ok);
    cov_ovr_c: cover property (@(posedge aclk) disable iff (!aresetn) rx_overrun);
    cov_quad_c: cover property (@(posedge aclk) disable iff (!aresetn)
        load_fg && fmode_r == 2'd2 && hit_nxt == 2'd3);
    cov_send_c: cover property (@(posedge aclk) disable iff (!aresetn) tx_done && sched_valid_r);
endmodule // ctsf_core

// File: pkg/ctsf_pkg.sv
package ctsf_pkg;
    localparam int NUM_TXB = 3;
    localparam int MSG_BYTES = 13;
    localparam int LOCAL_PRIORITY_W = 8;
    localparam int WARN_LIMIT = 96;
    localparam int PASSIVE_LIMIT = 127;
    localparam int BUSOFF_LIMIT = 255;
    localparam int CNT_W = 9;
    // Register byte addresses
    localparam logic [7:0] REG_TX_FLAG = 8'h00;
    localparam logic [7:0] REG_TX_CTRL = 8'h04;
    localparam logic [7:0] REG_RX_FLAG = 8'h08;
    localparam logic [7:0] REG_RX_EN = 8'h0c;
    localparam logic [7:0] REG_ACC_CTRL = 8'h10;
    localparam logic [7:0] REG_PATTERN = 8'h14;
    localparam logic [7:0] REG_MASK = 8'h18;
    localparam logic [7:0] REG_LOCAL_PRIORITY = 8'h1c;
    localparam logic [7:0] REG_SLEEP = 8'h20;
    // Receive flag register fields
    localparam int RF_WUP = 7;
    localparam int RF_RWRN = 6;
    localparam int RF_TWRN = 5;
    localparam int RF_RERR = 4;
    localparam int RF_TERR = 3;
    localparam int RF_BOFF = 2;
    localparam int RF_OVR = 1;
    localparam int RF_RXF = 0;
    localparam logic [7:0] RF_RESET = 8'h00;
    localparam logic [7:0] RX_EN_RESET = 8'h00;
    localparam logic [2:0] TXE_RESET = 3'h7;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
    typedef enum logic [1:0] {FM_SINGLE, FM_DUAL, FM_QUAD, FM_OFF} ctsf_fmode_t;
endpackage

// File: pkg/ctsf_sel_if.sv
`timescale 1ns/1ns
interface ctsf_sel_if;
    import ctsf_pkg::*;
    logic [NUM_TXB-1:0] pending;
    logic [NUM_TXB*LOCAL_PRIORITY_W-1:0] local_priority;
    logic found;
    logic [1:0] winner;
    modport top (output pending, output local_priority, input found, input winner);
    modport sel (input pending, input local_priority, output found, output winner);
endinterface

// File: rtl/ctsf_tx_select.sv
`timescale 1ns/1ns
module ctsf_tx_select
    import ctsf_pkg::*;
(
    ctsf_sel_if.sel s
);
    logic [LOCAL_PRIORITY_W-1:0] p0;
    logic [LOCAL_PRIORITY_W-1:0] p1;
    logic [LOCAL_PRIORITY_W-1:0] p2;
    logic w01;
    logic [LOCAL_PRIORITY_W-1:0] p01;
    logic [1:0] i01;
    logic v01;
    assign p0 = s.local_priority[LOCAL_PRIORITY_W-1:0];
    assign p1 = s.local_priority[2*LOCAL_PRIORITY_W-1:LOCAL_PRIORITY_W];
    assign p2 = s.local_priority[3*LOCAL_PRIORITY_W-1:2*LOCAL_PRIORITY_W];
    // Ties go to the lower buffer index
    assign w01 = s.pending[0] && (!s.pending[1] || p0 <= p1); // RL5
    assign v01 = s.pending[0] || s.pending[1];
    assign p01 = w01 ? p0 : p1;
    assign i01 = w01 ? 2'd0 : 2'd1;
    assign s.found = v01 || s.pending[2];
    assign s.winner = (v01 && (!s.pending[2] || p01 <= p2)) ? i01 : 2'd2; // RL5
endmodule // ctsf_tx_select

// File: bench/ctsf_engine_model.sv
`timescale 1ns/1ns
module ctsf_engine_model (
    input wire logic aclk,
    output logic tx_arb_start,
    output logic tx_active,
    output logic tx_done,
    output logic rx_eof,
    output logic [31:0] rx_id,
    output logic rx_own
);
    initial begin
        tx_arb_start = 1'b0;
        tx_active = 1'b0;
        tx_done = 1'b0;
        rx_eof = 1'b0;
        rx_id = 32'h0;
        rx_own = 1'b0;
    end
    // One pulse per arbitration attempt, retries included
    task automatic arb();
        @(posedge aclk) tx_arb_start <= 1'b1;
        @(posedge aclk) tx_arb_start <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask
    task automatic tx_begin();
        @(posedge aclk) tx_active <= 1'b1;
    endtask
    // Done pulse lands while the frame is still on the wire
    task automatic tx_end();
        repeat (3) @(posedge aclk);
        tx_done <= 1'b1;
        @(posedge aclk) tx_done <= 1'b0;
        tx_active <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask
    task automatic rx_frame(input logic [31:0] id, input logic own);
        @(posedge aclk) rx_eof <= 1'b1;
        rx_id <= id;
        rx_own <= own;
        @(posedge aclk) rx_eof <= 1'b0;
        // Stale id would hide a late sample
        rx_id <= ~id;
        repeat (2) @(posedge aclk);
    endtask
endmodule // ctsf_engine_model

// File: bench/ctsf_bench.sv
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module ctsf_bench;
    import ctsf_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, tx_sel, hit_index;
    logic [31:0] s_axi_rdata, rx_id;
    logic tx_arb_start, tx_done, tx_active, rx_eof, rx_own, tx_req, fg_load;
    logic loopback = 1'b0, sleep_mode = 1'b0, bus_activity = 1'b0;
    logic [CNT_W-1:0] rx_err_cnt = '0, tx_err_cnt = '0;
    logic irq_wakeup, irq_error, irq_rx, irq_tx;
    logic [8:0] tr [6] = '{9'd95, 9'd96, 9'd128, 9'd0, 9'd0, 9'd0};
    logic [8:0] tt [6] = '{9'd0, 9'd0, 9'd0, 9'd96, 9'd128, 9'd256};
    int fail_count = 0, checks = 0, loads = 0;
    logic [31:0] d;
    logic [1:0] r;

    always #10 aclk = ~aclk;
    always @(posedge aclk) if (fg_load === 1'b1) loads++;

    ctsf_core dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_arb_start, .tx_req, .tx_sel,
        .tx_done, .tx_active, .rx_eof, .rx_id, .rx_own, .loopback, .sleep_mode, .bus_activity, .rx_err_cnt,
        .tx_err_cnt, .fg_load, .hit_index, .irq_wakeup, .irq_error, .irq_rx, .irq_tx);
    ctsf_engine_model eng (.aclk, .tx_arb_start, .tx_active, .tx_done, .rx_eof, .rx_id, .rx_own);

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            aw = aw | s_axi_awready;
            w = w | s_axi_wready;
            s_axi_awvalid <= !aw;
            s_axi_wvalid <= !w;
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    // Returns hit and index; lowest filter wins
    function automatic logic [2:0] filt(input logic [1:0] m, input logic [31:0] p, k, id);
        logic [31:0] x;
        x = ~(id ^ p) | k;
        if (m == 2'd0) return {&x, 2'd0};
        if (m == 2'd1) return &x[31:16] ? 3'b100 : &x[15:0] ? 3'b101 : 3'b000;
        if (m == 2'd2) for (int i = 0; i < 4; i++) if (&x[31-8*i -: 8]) return {1'b1, i[1:0]};
        return 3'b000;
    endfunction
    // Ties go to the lower buffer index
    function automatic logic [1:0] pick(input logic [2:0] pend, input logic [23:0] pr);
        logic [1:0] w;
        logic [8:0] best;
        best = 9'h100;
        w = 2'd0;
        for (int i = 0; i < 3; i++) if (pend[i] && {1'b0, pr[8*i +: 8]} < best) begin
            w = i[1:0];
            best = {1'b0, pr[8*i +: 8]};
        end
        return w;
    endfunction
    function automatic logic [4:0] errs(input logic [CNT_W-1:0] rc, tc);
        return {rc >= WARN_LIMIT, tc >= WARN_LIMIT, rc > PASSIVE_LIMIT, tc > PASSIVE_LIMIT, tc > BUSOFF_LIMIT};
    endfunction
    task automatic wrap_up();
        if (fail_count == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Budget well above the expected run length
    initial begin
        #400000;
        fail_count++;
        wrap_up();
    end

    initial begin
        logic [23:0] pr;
        logic [2:0] pend, fr;
        logic [31:0] p, k, id;
        logic [1:0] m, w;
        logic [4:0] e;
        int n, n2;
        void'($urandom(7));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd(REG_TX_FLAG);
        `CHK(d[6:0], 7'h07)
        rd(REG_RX_FLAG);
        `CHK(d[7:0], RF_RESET)
        `CHK({irq_wakeup, irq_error, irq_rx, irq_tx}, 4'h0)
        rd(8'h40);
        `CHK({r, d}, {AXI_SLVERR, 32'h0})
        wr(8'h40, 32'h0);
        `CHK(r, AXI_SLVERR)
        wr(REG_TX_FLAG, 32'h70);
        `CHK(irq_tx, 1'b1)
        for (n = 0; n < 24; n++) begin
            pr = 24'($urandom);
            if (n % 3 == 0) pr[15:8] = pr[7:0];
            wr(REG_LOCAL_PRIORITY, {8'h0, pr});
            wr(REG_TX_FLAG, 32'h77);
            `CHK(irq_tx, 1'b0)
            pend = 3'h7;
            repeat (3) begin
                eng.arb();
                w = pick(pend, pr);
                `CHK({tx_req, tx_sel}, {1'b1, w})
                eng.tx_begin();
                eng.tx_end();
                pend[w] = 1'b0;
                `CHK(tx_req, 1'b0)
                rd(REG_TX_FLAG);
                `CHK(d[2:0], ~pend)
                rd(REG_TX_CTRL);
                `CHK(d[6:4], 3'h0)
            end
            `CHK(irq_tx, 1'b1)
        end
        wr(REG_LOCAL_PRIORITY, 32'h0905);
        wr(REG_TX_FLAG, 32'h73);
        eng.arb();
        `CHK(tx_sel, 2'd0)
        wr(REG_LOCAL_PRIORITY, 32'h0105);
        eng.arb();
        `CHK(tx_sel, 2'd1)
        eng.tx_begin();
        eng.tx_end();
        wr(REG_TX_CTRL, 32'h01);
        rd(REG_TX_FLAG);
        `CHK(d[2:0], 3'h7)
        rd(REG_TX_CTRL);
        `CHK(d[6:4], 3'h1)
        `CHK(irq_tx, 1'b1)
        wr(REG_TX_FLAG, 32'h74);
        eng.arb();
        `CHK(tx_sel, 2'd2)
        eng.tx_begin();
        wr(REG_TX_CTRL, 32'h04);
        rd(REG_TX_FLAG);
        `CHK(d[2:0], 3'h3)
        eng.tx_end();
        rd(REG_TX_CTRL);
        `CHK(d[6:4], 3'h1)
        wr(REG_RX_EN, 32'h01);
        for (n = 0; n < 60; n++) begin
            m = 2'(n % 4);
            p = $urandom;
            k = $urandom & $urandom;
            id = p ^ ($urandom & k);
            if (n % 3 == 1) id = id ^ (32'h1 << ($urandom % 32));
            wr(REG_ACC_CTRL, {30'h0, m});
            wr(REG_PATTERN, p);
            wr(REG_MASK, k);
            fr = filt(m, p, k, id);
            n2 = loads;
            eng.rx_frame(id, 1'b0);
            `CHK(loads - n2, int'(fr[2]))
            if (fr[2]) `CHK(hit_index, fr[1:0])
            rd(REG_RX_FLAG);
            `CHK(d[0], fr[2])
            `CHK(irq_rx, fr[2])
            wr(REG_RX_FLAG, 32'h01);
        end
        wr(REG_ACC_CTRL, 32'h0);
        wr(REG_MASK, 32'hffffffff);
        n2 = loads;
        eng.rx_frame($urandom, 1'b1);
        `CHK(loads - n2, 0)
        loopback <= 1'b1;
        eng.rx_frame($urandom, 1'b1);
        `CHK(loads - n2, 1)
        loopback <= 1'b0;
        wr(REG_RX_FLAG, 32'h01);
        wr(REG_RX_EN, 32'h02);
        n2 = loads;
        repeat (3) eng.rx_frame($urandom, 1'b0);
        `CHK(loads - n2, 1)
        rd(REG_RX_FLAG);
        `CHK(d[1:0], 2'h3)
        `CHK(irq_error, 1'b1)
        wr(REG_RX_FLAG, 32'h03);
        `CHK(loads - n2, 2)
        wr(REG_RX_FLAG, 32'h01);
        rd(REG_RX_FLAG);
        `CHK(d[1:0], 2'h0)
        wr(REG_RX_EN, 32'h7c);
        for (n = 0; n < 14; n++) begin
            rx_err_cnt <= n < 6 ? tr[n] : 9'($urandom);
            tx_err_cnt <= n < 6 ? tt[n] : 9'($urandom);
            repeat (3) @(posedge aclk);
            wr(REG_RX_FLAG, 32'h7c);
            e = errs(rx_err_cnt, tx_err_cnt);
            rd(REG_RX_FLAG);
            `CHK(d[6:2], e)
            `CHK(irq_error, |e)
        end
        rx_err_cnt <= '0;
        tx_err_cnt <= '0;
        repeat (3) @(posedge aclk);
        rd(REG_RX_FLAG);
        `CHK(d[6:2], e)
        wr(REG_RX_FLAG, 32'h7c);
        rd(REG_RX_FLAG);
        `CHK(d[6:2], 5'h0)
        wr(REG_RX_EN, 32'h80);
        sleep_mode <= 1'b1;
        bus_activity <= 1'b1;
        repeat (3) @(posedge aclk);
        sleep_mode <= 1'b0;
        bus_activity <= 1'b0;
        rd(REG_RX_FLAG);
        `CHK(d[7], 1'b1)
        `CHK({irq_wakeup, irq_error}, 2'b10)
        wr(REG_RX_FLAG, 32'h80);
        `CHK(irq_wakeup, 1'b0)
        wrap_up();
    end
endmodule // ctsf_bench
